//--- core/pds_pkg.sv
// package: constants and carrier types for the prbs source and error checker
package pds_pkg;
  localparam int          CLK_HZ          = 20000000;
  localparam int          GEN_NUM         = 3;
  localparam int          GEN_LOW         = 0;
  localparam int          GEN_HIGH        = 1;
  localparam int          GEN_SPREAD      = 2;
  localparam int          REG_MAXW        = 13;
  localparam int          GEN_W [GEN_NUM] = '{10, 13, 11};
  // tap masks; bit k set means stage k+1 feeds back
  localparam logic [12:0] GEN_TAPS [GEN_NUM] = '{13'h0204, 13'h1B00, 13'h0500};
  localparam logic        GEN_HALVE [GEN_NUM] = '{1'b1, 1'b1, 1'b0};
  // master (twice bit rate) and chip rates in hertz
  localparam longint      MASTER_HZ_144   = 144000;
  localparam longint      MASTER_HZ_432   = 432000;
  localparam longint      MASTER_HZ_6M    = 6000000;
  localparam longint      CHIP_HZ         = 14100000;
  localparam logic [31:0] INC_144  = 32'((MASTER_HZ_144 << 32) / CLK_HZ);
  localparam logic [31:0] INC_432  = 32'((MASTER_HZ_432 << 32) / CLK_HZ);
  localparam logic [31:0] INC_6M   = 32'((MASTER_HZ_6M << 32) / CLK_HZ);
  localparam logic [31:0] INC_CHIP = 32'((CHIP_HZ << 32) / CLK_HZ);
  // dump pulse lengths per rate
  localparam int          DUMP_NS_72      = 1000;
  localparam int          DUMP_NS_216     = 500;
  localparam logic [5:0]  DUMP_CYC_72     = 6'((DUMP_NS_72 * (CLK_HZ / 1000000) + 999) / 1000);
  localparam logic [5:0]  DUMP_CYC_216    = 6'((DUMP_NS_216 * (CLK_HZ / 1000000) + 999) / 1000);
  // register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_DLY72      = 8'h04;
  localparam logic [7:0]  ADDR_DLY216     = 8'h08;
  localparam logic [7:0]  ADDR_DLY3M      = 8'h0C;
  localparam logic [7:0]  ADDR_ERRCNT     = 8'h10;
  localparam int          CTRL_BIPHASE    = 0;
  localparam int          CTRL_CNTCLR     = 1;
  localparam int          CTRL_DATARST    = 2;
  localparam logic [5:0]  DLY72_RST       = 6'h10;
  localparam logic [5:0]  DLY216_RST      = 6'h08;
  localparam logic [5:0]  DLY3M_RST       = 6'h02;
  localparam int          DLY_DEPTH       = 64;
  localparam logic [15:0] ERRCNT_MAX      = 16'hFFFF;

  typedef struct packed {
    logic baseband;
    logic basebandN;
    logic lineCoded;
    logic lineCodedN;
    logic wordSync;
  } pds_src_out_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } pds_reg_req_t;
endpackage

//--- core/pds_core.sv
// module: three prbs generators, demod clocking and bit error checker
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module pds_core
  import pds_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire pds_pkg::pds_reg_req_t regReq,
  output logic [31:0]                regRdData,
  input  wire logic                  compDecision,
  input  wire logic                  dataResetBtn,
  output pds_pkg::pds_src_out_t      lowOut,
  output pds_pkg::pds_src_out_t      highOut,
  output logic                       spreadChip,
  output logic                       spreadSync,
  output logic                       lowDemodClk,
  output logic                       highDemodClk,
  output logic                       dumpCmd,
  output logic                       integSlow,
  output logic                       reconData,
  output logic                       refData,
  output logic                       bitErr,
  output logic [15:0]                errCount
);
  import pds_pkg::*;

  // control registers
  logic        biphase_reg;
  logic [5:0]  dly72_reg;
  logic [5:0]  dly216_reg;
  logic [5:0]  dly3m_reg;
  logic [15:0] errCnt_reg;
  logic [15:0] errCnt_next;

  wire wrCtrl  = regReq.wr && (regReq.addr == ADDR_CTRL);
  wire wrDly72 = regReq.wr && (regReq.addr == ADDR_DLY72);
  wire wrDly216 = regReq.wr && (regReq.addr == ADDR_DLY216);
  wire wrDly3m = regReq.wr && (regReq.addr == ADDR_DLY3M);
  wire cntClr  = wrCtrl && regReq.wrData[CTRL_CNTCLR];
  wire swDataRst = wrCtrl && regReq.wrData[CTRL_DATARST];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      biphase_reg <= 1'b0;
      dly72_reg   <= DLY72_RST;
      dly216_reg  <= DLY216_RST;
      dly3m_reg   <= DLY3M_RST;
    end else begin
      if (wrCtrl) biphase_reg <= regReq.wrData[CTRL_BIPHASE];
      if (wrDly72) dly72_reg <= regReq.wrData[5:0];
      if (wrDly216) dly216_reg <= regReq.wrData[5:0];
      if (wrDly3m) dly3m_reg <= regReq.wrData[5:0];
    end
  end

  wire [31:0] rdMux =
    (regReq.addr == ADDR_CTRL)   ? {31'h0, biphase_reg} :
    (regReq.addr == ADDR_DLY72)  ? {26'h0, dly72_reg} :
    (regReq.addr == ADDR_DLY216) ? {26'h0, dly216_reg} :
    (regReq.addr == ADDR_DLY3M)  ? {26'h0, dly3m_reg} :
    (regReq.addr == ADDR_ERRCNT) ? {16'h0, errCnt_reg} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) regRdData <= 32'h0;
    else if (regReq.rd) regRdData <= rdMux;
    else regRdData <= 32'h0;
  end

  // pin synchronisers
  logic [1:0] btnSync;
  logic [1:0] decSync;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      btnSync <= 2'h0;
      decSync <= 2'h0;
    end else begin
      btnSync <= {btnSync[0], dataResetBtn};
      decSync <= {decSync[0], compDecision};
    end
  end
  wire dataRst = rst || btnSync[1] || swDataRst;

  // rate selection: biphase mode runs 216 kbps, quadriphase runs 72 kbps plus 3 Mbps
  wire [31:0] lowInc = biphase_reg ? INC_432 : INC_144;
  wire [31:0] incSel [GEN_NUM] = '{lowInc, INC_6M, INC_CHIP};
  wire        genRun [GEN_NUM] = '{1'b1, ~biphase_reg, 1'b1};

  logic [REG_MAXW-1:0] lfsrState [GEN_NUM];
  logic                shiftEn   [GEN_NUM];
  logic                halfClk   [GEN_NUM];
  logic                prevBit   [GEN_NUM];
  pds_src_out_t        srcOut    [GEN_NUM];

  // generators share one structure; widths and taps come from the tables
  for (genvar g = 0; g < GEN_NUM; g++) begin : gen_src
    localparam logic [REG_MAXW-1:0] WMASK = 13'((14'h1 << GEN_W[g]) - 14'h1);
    logic [31:0]         ncoAcc;
    logic                masterEn;
    logic [REG_MAXW-1:0] st;
    logic                halfReg;
    wire  [32:0]         ncoSum = {1'b0, ncoAcc} + {1'b0, incSel[g]};
    // xnor feedback so all zeros is a legal start state
    wire                 fb = ~(^(st & GEN_TAPS[g]));
    wire                 lockup = (st == WMASK);
    wire                 step = GEN_HALVE[g] ? (masterEn && !halfReg) : masterEn;
    wire [REG_MAXW-1:0]  stNext = lockup ? 13'h0 : ({st[REG_MAXW-2:0], fb} & WMASK);

    always_ff @(posedge sys_clk) begin
      if (dataRst || !genRun[g]) begin
        ncoAcc   <= 32'h0;
        masterEn <= 1'b0;
        st       <= 13'h0;
        halfReg  <= 1'b0;
        prevBit[g] <= 1'b0;
        // pairs stay complementary even while held in reset
        srcOut[g]  <= '{baseband: 1'b0, basebandN: 1'b1, lineCoded: 1'b0,
                        lineCodedN: 1'b1, wordSync: 1'b0};
      end else begin
        ncoAcc   <= ncoSum[31:0];
        masterEn <= ncoSum[32];
        if (masterEn && GEN_HALVE[g]) halfReg <= ~halfReg;
        if (step || lockup) st <= stNext;
        if (step) prevBit[g] <= st[GEN_W[g]-1];
        srcOut[g].baseband   <= st[GEN_W[g]-1];
        srcOut[g].basebandN  <= ~st[GEN_W[g]-1];
        // biphase-l: true data in first half bit, inverted in second
        srcOut[g].lineCoded  <= st[GEN_W[g]-1] ^ ~halfReg;
        srcOut[g].lineCodedN <= ~(st[GEN_W[g]-1] ^ ~halfReg);
        srcOut[g].wordSync   <= step && (st == 13'h0);
      end
    end
    assign lfsrState[g] = st;
    assign shiftEn[g]   = step;
    assign halfClk[g]   = halfReg;
  end

  assign lowOut     = srcOut[GEN_LOW];
  assign highOut    = srcOut[GEN_HIGH];
  assign spreadChip = srcOut[GEN_SPREAD].baseband;
  assign spreadSync = srcOut[GEN_SPREAD].wordSync;

  // delayed demod clocks: tapped delay lines, tap chosen by the rate in use
  logic [DLY_DEPTH-1:0] lowLine;
  logic [DLY_DEPTH-1:0] highLine;
  wire  [5:0]           lowTap = biphase_reg ? dly216_reg : dly72_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lowLine      <= '0;
      highLine     <= '0;
      lowDemodClk  <= 1'b0;
      highDemodClk <= 1'b0;
    end else begin
      lowLine      <= {lowLine[DLY_DEPTH-2:0], halfClk[GEN_LOW]};
      highLine     <= {highLine[DLY_DEPTH-2:0], halfClk[GEN_HIGH]};
      lowDemodClk  <= lowLine[lowTap];
      highDemodClk <= highLine[dly3m_reg];
    end
  end

  // bit reconstruct on the low-rate channel
  logic       demodPrev;
  logic [5:0] dumpCnt;
  logic       capStrobe;
  wire        bitEdge = lowDemodClk && !demodPrev;
  wire [5:0]  dumpLen = biphase_reg ? DUMP_CYC_216 : DUMP_CYC_72;
  wire        mismatch = reconData ^ refData;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      demodPrev <= 1'b0;
      dumpCnt   <= 6'h0;
      dumpCmd   <= 1'b0;
      integSlow <= 1'b0;
      reconData <= 1'b0;
      refData   <= 1'b0;
      capStrobe <= 1'b0;
      bitErr    <= 1'b0;
    end else begin
      demodPrev <= lowDemodClk;
      integSlow <= ~biphase_reg;
      capStrobe <= bitEdge;
      if (bitEdge) begin
        dumpCnt   <= dumpLen;
        dumpCmd   <= 1'b1;
        reconData <= decSync[1];
        refData   <= prevBit[GEN_LOW];
      end else if (dumpCnt > 6'h1) begin
        dumpCnt <= dumpCnt - 6'h1;
      end else begin
        dumpCnt <= 6'h0;
        dumpCmd <= 1'b0;
      end
      bitErr <= capStrobe && mismatch;
    end
  end

  // error counter saturates; a pulse in the clear cycle still counts
  always_comb begin
    errCnt_next = errCnt_reg;
    if (cntClr) errCnt_next = 16'h0;
    if (bitErr && errCnt_next != ERRCNT_MAX) errCnt_next = errCnt_next + 16'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) errCnt_reg <= 16'h0;
    else errCnt_reg <= errCnt_next;
  end
  assign errCount = errCnt_reg;

  // checks
  lfsr_no_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
    (lfsrState[GEN_LOW][9:0] == 10'h3FF) |=> (lfsrState[GEN_LOW] == 13'h0))
    else $error("low lfsr stayed in lockup");
  hi_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    biphase_reg [*3] |-> (lfsrState[GEN_HIGH] == 13'h0))
    else $error("high source ran in biphase mode");
  pair_comp_a: assert property (@(posedge sys_clk) disable iff (rst)
    lowOut.baseband != lowOut.basebandN)
    else $error("baseband pair not complementary");
  code_pair_a: assert property (@(posedge sys_clk) disable iff (rst)
    lowOut.lineCoded != lowOut.lineCodedN)
    else $error("coded pair not complementary");
  step_half_a: assert property (@(posedge sys_clk) disable iff (rst)
    shiftEn[GEN_LOW] |=> !shiftEn[GEN_LOW] [*2])
    else $error("low shift faster than half master");
  sync_zero_a: assert property (@(posedge sys_clk) disable iff (dataRst)
    srcOut[GEN_SPREAD].wordSync |-> $past(lfsrState[GEN_SPREAD]) == 13'h0)
    else $error("spread sync off word start");
  dump_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    bitEdge |=> dumpCmd)
    else $error("no dump after bit edge");
  err_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    bitErr |-> $past(capStrobe) && $past(reconData != refData))
    else $error("error pulse without mismatch");
  err_single_a: assert property (@(posedge sys_clk) disable iff (rst)
    bitErr |=> !bitErr)
    else $error("error pulse longer than one cycle");
  cnt_inc_a: assert property (@(posedge sys_clk) disable iff (rst)
    (bitErr && !cntClr && errCnt_reg != ERRCNT_MAX) |=> errCnt_reg == $past(errCnt_reg) + 16'h1)
    else $error("error not counted");
  recon_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
    bitEdge |=> reconData == $past(decSync[1]))
    else $error("decision not captured");
endmodule

//--- sim/pds_far_end.sv
// far-side model: demodulator decision fed back from the low-rate baseband
`timescale 1ns/1ps
module pds_far_end (
  input  wire logic sys_clk,
  input  wire logic baseband,
  input  wire logic invert,
  output logic      compDecision
);
  // inverting stands in for a channel too noisy to get any bit right
  initial compDecision = 1'b0;
  always @(posedge sys_clk) begin
    compDecision <= baseband ^ invert;
  end
endmodule

//--- sim/pds_core_bench.sv
// testbench: register rows, then generator timing and error counting
`timescale 1ns/1ps
module pds_core_bench;
  import pds_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pds_row_t;
  logic                  sys_clk, rst, compDecision, dataResetBtn, invert, prevErr;
  pds_reg_req_t          regReq;
  logic [31:0]           regRdData, rd;
  pds_src_out_t          lowOut, highOut;
  logic                  spreadChip, spreadSync, lowDemodClk, highDemodClk, dumpCmd;
  logic                  integSlow, reconData, refData, bitErr, rstD;
  logic [15:0]           errCount;
  int                    bad_count, n_checks, cyc, expCnt, dbl, cmpBad, n;
  pds_row_t rows [9] = '{
    '{1'b0, ADDR_CTRL,   32'h0, 32'h0},
    '{1'b0, ADDR_DLY72,  32'h0, 32'(DLY72_RST)},
    '{1'b0, ADDR_DLY216, 32'h0, 32'(DLY216_RST)},
    '{1'b0, ADDR_DLY3M,  32'h0, 32'(DLY3M_RST)},
    '{1'b0, ADDR_ERRCNT, 32'h0, 32'h0},
    '{1'b1, ADDR_DLY216, 32'hFFFFFFFF, 32'h3F},
    '{1'b1, ADDR_DLY3M,  32'h15, 32'h15},
    '{1'b1, 8'h14,       32'h12345678, 32'h0},
    '{1'b1, ADDR_CTRL,   32'h7, 32'h1}};

  pds_core u_dut (.sys_clk(sys_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .compDecision(compDecision), .dataResetBtn(dataResetBtn), .lowOut(lowOut),
    .highOut(highOut), .spreadChip(spreadChip), .spreadSync(spreadSync),
    .lowDemodClk(lowDemodClk), .highDemodClk(highDemodClk), .dumpCmd(dumpCmd),
    .integSlow(integSlow), .reconData(reconData), .refData(refData), .bitErr(bitErr),
    .errCount(errCount));
  pds_far_end u_far (.sys_clk(sys_clk), .baseband(lowOut.baseband), .invert(invert),
    .compDecision(compDecision));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // expected count follows the pulses; clear and error together leave one
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rstD <= rst;
    prevErr <= bitErr;
    if (rst) expCnt <= 0;
    else if (regReq.wr && regReq.addr == ADDR_CTRL && regReq.wrData[CTRL_CNTCLR])
      expCnt <= (bitErr === 1'b1) ? 1 : 0;
    else if (bitErr === 1'b1) expCnt <= expCnt + 1;
    if (bitErr === 1'b1 && prevErr === 1'b1) dbl <= dbl + 1;
    if (!rst && !rstD && (lowOut.basebandN !== ~lowOut.baseband ||
        lowOut.lineCodedN !== ~lowOut.lineCoded)) cmpBad <= cmpBad + 1;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task chkIn(input int got, input int lo, input int hi, input string msg);
    n_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  task regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wr <= 1'b1;
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
  endtask

  task regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1 d = regRdData;
  endtask

  // length of the next full run of lvl on s, sampled mid-cycle; waits are bounded
  task automatic runLen(ref logic s, input logic lvl, output int len);
    int k;
    len = 0;
    for (k = 0; k < 4000 && s === lvl; k++) @(negedge sys_clk);
    for (k = 0; k < 4000 && s !== lvl; k++) @(negedge sys_clk);
    for (k = 0; k < 4000 && s === lvl; k++) begin
      @(negedge sys_clk);
      len++;
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    regReq = '0;
    dataResetBtn = 1'b0;
    invert = 1'b0;
    {bad_count, n_checks, cyc, expCnt, dbl, cmpBad} = '0;
    repeat (6) @(posedge sys_clk);
    #1 chk({27'h0, lowOut}, 32'h0A, "low source in reset");
    chk({16'h0, errCount}, 32'h0, "count in reset");
    @(posedge sys_clk) rst <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].wr) regWrite(rows[i].a, rows[i].d);
      regRead(rows[i].a, rd);
      chk(rd, rows[i].e, "register row");
    end
    $display("register rows done");
    repeat (5) @(negedge sys_clk);
    chk({31'h0, integSlow}, 32'h0, "fast time constant");
    runLen(dumpCmd, 1'b1, n);
    chkIn(n, DUMP_CYC_216, DUMP_CYC_216, "dump length 216k");
    runLen(lowDemodClk, 1'b1, n);
    chkIn(n, 46, 47, "half bit 216k");
    chk({27'h0, highOut}, 32'h0A, "high source in biphase");
    runLen(spreadSync, 1'b0, n);
    chkIn(n + 1, 2903, 2904, "spread word length");
    runLen(spreadSync, 1'b1, n);
    chkIn(n, 1, 1, "spread sync width");
    $display("biphase and spread test done");
    @(posedge sys_clk) invert <= 1'b1;
    repeat (1500) @(negedge sys_clk);
    chk({16'h0, errCount}, 32'(expCnt), "error count");
    chkIn(expCnt, 1, 100, "errors seen");
    regWrite(ADDR_CTRL, 32'h3);
    @(negedge sys_clk);
    chk({16'h0, errCount}, 32'(expCnt), "count after clear");
    chkIn(expCnt, 0, 1, "cleared count");
    chkIn(dbl, 0, 0, "error pulse width");
    invert <= 1'b0;
    $display("error count test done");
    regWrite(ADDR_CTRL, 32'h0);
    repeat (3) @(negedge sys_clk);
    chk({31'h0, integSlow}, 32'h1, "slow time constant");
    runLen(dumpCmd, 1'b1, n);
    chkIn(n, DUMP_CYC_72, DUMP_CYC_72, "dump length 72k");
    runLen(lowDemodClk, 1'b1, n);
    chkIn(n, 138, 139, "half bit 72k");
    runLen(highDemodClk, 1'b1, n);
    chkIn(n, 3, 4, "half bit 3M");
    chk({30'h0, highOut.basebandN, highOut.lineCodedN},
        {30'h0, ~highOut.baseband, ~highOut.lineCoded}, "high pairs");
    chkIn(cmpBad, 0, 0, "low pairs");
    $display("quadriphase test done");
    summarize();
  end
endmodule
